/* uart_line_format_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ulfc_params.svh"
// ==========================================================
// Bench top: register, stream and serial line scenarios.
// ==========================================================
module uart_line_format_control_tb;
    logic        ref_clk = 1'b0;  // Reference clock.
    logic        rst_b = 1'b0;    // Reset, active low.
    logic [31:0] reg_addr = 32'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        fifo_on = 1'b0;
    logic [5:0]  rx_trigger = 6'h00;
    logic        rts_req = 1'b0;
    logic [7:0]  tx_data = 8'h00;
    logic        tx_valid = 1'b0;
    logic        tx_ready, rx_valid, rx_frame_err, rx_parity_err;
    logic [7:0]  rx_data;
    logic        rx_ready = 1'b1;
    logic        sin, sout, sir_out_n, rts_n;
    int          error_cnt = 0;    // Mismatches seen.
    int          total_checks = 0; // Comparisons made.
    int          c, e, i, n;
    logic [15:0] v;
    logic [7:0]  d, b;
    logic        p, q;
    realtime     t0, t1;
    logic [15:0] fmt [3] = '{16'h0004, 16'h001B, 16'h000E};
    logic [15:0] rfm [4] = '{16'h001F, 16'h000F, 16'h001F, 16'h0007};
    logic [7:0]  rdt [4] = '{8'h96, 8'h96, 8'h5A, 8'h5A};
    logic [3:0]  flp = 4'b0100;    // Cases sent with wrong parity.
    logic [3:0]  stp = 4'b0111;    // Stop level sent per case.

    ulfc_top dut_u (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .fifo_on, .rx_trigger, .rts_req, .tx_data,
        .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .rx_frame_err,
        .rx_parity_err, .sin, .sir_in(1'b0), .sout, .sir_out_n, .rts_n);
    ulfc_remote rmt_u (.ref_clk, .sout, .sin);

    // The clock toggles every half period of 2.5 ns.
    initial forever #2.5 ref_clk = ~ref_clk;

    // Compares a value seen with the value expected.
    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle register write.
    task wr(input logic [31:0] a, input logic [15:0] w);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle register read; data stand in the following cycle.
    task rd(input logic [31:0] a, output logic [15:0] r);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask : rd

    // Offers one word to the transmit stream until it is taken.
    task push(input logic [7:0] w);
        @(posedge ref_clk);
        tx_data <= w;
        tx_valid <= 1'b1;
        do @(posedge ref_clk); while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
    endtask : push

    // Waits, bounded, for a received word.
    task rxwait(output logic [7:0] w);
        int k;
        for (k = 0; k < 400 && rx_valid !== 1'b1; k++)
            @(posedge ref_clk) #1;
        w = rx_data;
    endtask : rxwait

    // Counts cycles with sout (sel 0) or sir_out_n (sel 1) high.
    task count(input logic sel, input int cyc, output int cn);
        cn = 0;
        repeat (cyc)
        begin
            @(posedge ref_clk) #1;
            cn += int'((sel ? sir_out_n : sout) === 1'b1);
        end
    endtask : count

    // Prints the counts and the verdict, then ends the run.
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // Cuts a hang short after about 40,000 cycles.
    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end

    // ======================================================
    // Main sequence.
    // ======================================================
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(`ULFC_LFC_OFFSET, v); check(v, 16'h0000);
        rd(`ULFC_MLC_OFFSET, v); check(v, 16'h0000);
        wr(`ULFC_LFC_OFFSET, 16'hFFFF);
        wr(`ULFC_MLC_OFFSET, 16'hFFFF);
        rd(`ULFC_LFC_OFFSET, v); check(v, 16'h005F);
        rd(`ULFC_MLC_OFFSET, v); check(v, 16'h0070);
        rd(32'h50001014, v); check(v, 16'h0000);
        wr(`ULFC_MLC_OFFSET, 16'h0000);
        $display("test registers done");
        // Transmit formats; spacing shows parity and stop length.
        for (i = 0; i < 3; i++)
        begin
            wr(`ULFC_LFC_OFFSET, fmt[i]);
            n = int'(fmt[i][1:0]) + 5;
            fork
                begin push(8'h91); push(8'hF1); end
                begin
                    rmt_u.grab(n, fmt[i][3], d, p, t0);
                    rmt_u.grab(n, fmt[i][3], b, q, t1);
                end
            join
            check(d, 8'h91 & (8'hFF >> (8 - n)));
            if (fmt[i][3]) check(p, ^d ^ !fmt[i][4]);
            e = 16 * (1 + n + fmt[i][3]) + 8 * (fmt[i][2] ? (n == 5 ? 3 : 4) : 2);
            c = int'((t1 - t0) / 5.0);
            check(c >= e && c <= e + 3, 1);
        end
        $display("test transmit done");
        // Receive cases, each sent with a single stop bit.
        for (i = 0; i < 4; i++)
        begin
            wr(`ULFC_LFC_OFFSET, rfm[i]);
            p = ^rdt[i] ^ ~rfm[i][4] ^ flp[i];
            fork
                rmt_u.send(rdt[i], 8, rfm[i][3], p, stp[i]);
                rxwait(d);
            join
            check(d, rdt[i]);
            check(rx_parity_err, flp[i]);
            check(rx_frame_err, !stp[i]);
        end
        $display("test receive done");
        // Flow control against the receive level.
        rx_ready <= 1'b0;
        fifo_on <= 1'b1;
        rts_req <= 1'b1;
        wr(`ULFC_MLC_OFFSET, 16'h0020);
        wr(`ULFC_LFC_OFFSET, 16'h0003);
        repeat (3) @(posedge ref_clk);
        check(rts_n, 1'b0);
        repeat (2) rmt_u.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
        repeat (3) @(posedge ref_clk);
        check(rts_n, 1'b1);
        fifo_on <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(rts_n, 1'b0);
        fifo_on <= 1'b1;
        wr(`ULFC_MLC_OFFSET, 16'h0000);
        repeat (3) @(posedge ref_clk);
        check(rts_n, 1'b0);
        rx_ready <= 1'b1;
        repeat (5) @(posedge ref_clk);
        $display("test flow done");
        // Infrared pulses for nine zero bits, then break.
        wr(`ULFC_MLC_OFFSET, 16'h0040);
        fork push(8'h00); count(1'b1, 200, c); join
        check(c, 27);
        wr(`ULFC_LFC_OFFSET, 16'h0043);
        count(1'b1, 100, c);
        check(c > 0 && c < 100, 1);
        wr(`ULFC_MLC_OFFSET, 16'h0000);
        count(1'b0, 100, c);
        check(c, 0);
        wr(`ULFC_LFC_OFFSET, 16'h0003);
        repeat (2) @(posedge ref_clk);
        check(sout, 1'b1);
        $display("test break done");
        // Loopback of data, then of a break.
        wr(`ULFC_MLC_OFFSET, 16'h0010);
        fork push(8'hC3); rxwait(d); count(1'b0, 150, c); join
        check(d, 8'hC3);
        check(c, 150);
        wr(`ULFC_LFC_OFFSET, 16'h0043);
        fork rxwait(d); count(1'b1, 150, c); join
        check(d, 8'h00);
        check(rx_frame_err, 1'b1);
        check(c, 0);
        wr(`ULFC_LFC_OFFSET, 16'h0003);
        wr(`ULFC_MLC_OFFSET, 16'h0000);
        $display("test loopback done");
        // Transmit buffer filled until full, then waited on until it has room again.
        c = 0;
        tx_valid <= 1'b1;
        repeat (40)
        begin
            @(posedge ref_clk);
            c += int'(tx_ready === 1'b1);
        end
        tx_valid <= 1'b0;
        #1 check(tx_ready, 1'b0);
        check(c >= 32 && c <= 34, 1);
        for (i = 0; i < 400 && tx_ready !== 1'b1; i++)
            @(posedge ref_clk) #1;
        check(tx_ready, 1'b1);
        $display("test buffer done");
        close_out();
    end
endmodule : uart_line_format_control_tb
`default_nettype wire

/* ulfc_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Synchronous FIFO with valid/ready on both sides.
// ==========================================================================
module ulfc_fifo #(
    parameter int W  = 8,
    parameter int AW = 5
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    input  wire logic [W-1:0]  in_data,
    input  wire logic          in_valid,
    output logic               in_ready,
    output logic [W-1:0]       out_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [AW:0]        level
);
    logic [W-1:0] mem [2**AW];  // Storage words.
    logic [AW:0]  wp_r;         // Write pointer with wrap bit.
    logic [AW:0]  rp_r;         // Read pointer with wrap bit.
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign level     = wp_r - rp_r;
    assign in_ready  = level != (AW+1)'(2**AW);
    assign out_valid = level != '0;
    assign out_data  = mem[rp_r[AW-1:0]];
    // Pointers advance on each accepted transfer.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop)  rp_r <= rp_r + 1'b1;
        end
    end
    // Storage is written without reset.
    always_ff @(posedge ref_clk)
    begin
        if (push) mem[wp_r[AW-1:0]] <= in_data;
    end
endmodule : ulfc_fifo
`default_nettype wire

/* ulfc_params.svh */
`ifndef ULFC_PARAMS_SVH
`define ULFC_PARAMS_SVH
// ==========================================================================
// Register map, field positions and reset values.
// ==========================================================================
`define ULFC_ADDR_W        32
`define ULFC_LFC_OFFSET    32'h5000100C
`define ULFC_MLC_OFFSET    32'h50001010
`define ULFC_LFC_RESET     16'h0000
`define ULFC_MLC_RESET     16'h0000
`define ULFC_LFC_MASK      16'h005F
`define ULFC_MLC_MASK      16'h0070
`define ULFC_LEN_LSB       0
`define ULFC_STOP_BIT      2
`define ULFC_PAR_BIT       3
`define ULFC_EVEN_BIT      4
`define ULFC_BRK_BIT       6
`define ULFC_LB_BIT        4
`define ULFC_AFC_BIT       5
`define ULFC_IR_BIT        6
// Bit time in reference clocks and infrared pulse width (3/16 of a bit).
`define ULFC_BIT_CYCLES    16'h0010
`define ULFC_IR_CYCLES     16'h0003
`define ULFC_FIFO_DEPTH    32
`define ULFC_FIFO_AW       5
`endif

/* ulfc_pkg.sv */
package ulfc_pkg;
    // Decoded character format handed between stages.
    typedef struct packed {
        logic [3:0] data_bits;   // Five to eight data bits.
        logic       parity_on;   // Parity bit present.
        logic       even;        // Even parity when set.
        logic [1:0] stop_halves; // Stop length in half bits: 2, 3 or 0 for 4.
    } ulfc_fmt_t;
    // Transmitter sequencer states.
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulfc_tx_t;
    // Receiver sequencer states.
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ulfc_rx_t;
endpackage : ulfc_pkg

/* ulfc_remote.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Remote serial device: frames onto sin, decodes sout.
// ==========================================================
module ulfc_remote (
    input  wire logic ref_clk, // Reference clock.
    input  wire logic sout,    // Serial line from the port.
    output logic      sin      // Serial line to the port.
);
    initial sin = 1'b1; // The line rests at mark.

    // Holds one bit on the line for a bit time of 16 clocks.
    task bit_out(input logic v);
        sin <= v;
        repeat (16) @(posedge ref_clk);
    endtask : bit_out

    // Sends start, data LSB first, optional parity and one stop bit.
    task send(input logic [7:0] d, input int n, input logic pe,
              input logic pb, input logic sv);
        int i;
        @(posedge ref_clk);
        bit_out(1'b0);
        for (i = 0; i < n; i++)
            bit_out(d[i]);
        if (pe)
            bit_out(pb);
        bit_out(sv); // A single stop bit only.
        sin <= 1'b1;
    endtask : send

    // Finds a start edge, then samples each bit in its middle.
    task grab(input int n, input logic pe, output logic [7:0] d,
              output logic pb, output realtime t);
        int i;
        d  = 8'h00;
        pb = 1'b0;
        repeat (2) @(posedge ref_clk);
        for (i = 0; i < 4000 && sout !== 1'b0; i++)
            @(posedge ref_clk);
        t = $realtime;
        repeat (8) @(posedge ref_clk);
        for (i = 0; i < n; i++)
        begin
            repeat (16) @(posedge ref_clk);
            d[i] = sout;
        end
        if (pe)
        begin
            repeat (16) @(posedge ref_clk);
            pb = sout;
        end
    endtask : grab
endmodule : ulfc_remote
`default_nettype wire

/* ulfc_top.sv */
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "ulfc_params.svh"
// ==========================================================================
// Line format control with a small serial engine.
// ==========================================================================
// Notes on behaviour
// - Break without loopback or infrared mode holds serial output low.
// - Break in infrared mode pulses infrared output.
// - Loopback routes break inward, infrared output low.
// - Parity sense one even, zero odd.
// - Parity enable adds and checks parity bit.
// - Stop bit one, 1.5 or two.
// - Receiver checks only first stop bit.
// - Length code selects five to eight bits.
// - Infrared enable selects pulse encoding.
// - Auto flow needs FIFOs enabled and enable bit.
// - Loopback returns transmit data to receiver.
// - Auto flow raises RTS above receive threshold.
module ulfc_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    input  wire logic        fifo_on,
    input  wire logic [5:0]  rx_trigger,
    input  wire logic        rts_req,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic             rx_frame_err,
    output logic             rx_parity_err,
    input  wire logic        sin,
    input  wire logic        sir_in,
    output logic             sout,
    output logic             sir_out_n,
    output logic             rts_n
);
    logic [15:0] lfc_r;            // Line format control register.
    logic [15:0] mlc_r;            // Modem line control register.
    logic [15:0] rdata_nxt;        // Read data for next cycle.
    ulfc_pkg::ulfc_fmt_t fmt;      // Decoded format.
    logic break_force;             // Break request.
    logic loopback_on;             // Diagnostic loopback.
    logic infrared_mode_on;        // Infrared encoding.
    logic auto_flow_on;            // Effective auto flow.

    // Fold bits into a parity value.
    function automatic logic par_of(input logic [7:0] d, input logic [3:0] n, input logic ev);
        logic p;
        p = 1'b0;
        for (int i = 0; i < 8; i++)
            if (4'(i) < n) p = p ^ d[i];
        // Even sense makes total ones even.
        return ev ? p : ~p;
    endfunction : par_of

    // ======================================================================
    // Register file.
    // ======================================================================
    // Writes keep only defined fields.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lfc_r <= `ULFC_LFC_RESET;
            mlc_r <= `ULFC_MLC_RESET;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `ULFC_LFC_OFFSET) lfc_r <= reg_wdata & `ULFC_LFC_MASK;
            if (reg_addr == `ULFC_MLC_OFFSET) mlc_r <= reg_wdata & `ULFC_MLC_MASK;
        end
    end

    // Read mux; unmapped addresses return zero.
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (reg_rd && reg_addr == `ULFC_LFC_OFFSET) rdata_nxt = lfc_r;
        else if (reg_rd && reg_addr == `ULFC_MLC_OFFSET) rdata_nxt = mlc_r;
    end

    // Read data stands one cycle after the strobe.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b) reg_rdata <= 16'h0000;
        else        reg_rdata <= rdata_nxt;
    end

    // Field decode.
    always_comb
    begin
        break_force      = lfc_r[`ULFC_BRK_BIT];
        loopback_on      = mlc_r[`ULFC_LB_BIT];
        infrared_mode_on = mlc_r[`ULFC_IR_BIT];
        auto_flow_on     = mlc_r[`ULFC_AFC_BIT] && fifo_on;
        fmt.data_bits    = 4'h5 + {2'b00, lfc_r[`ULFC_LEN_LSB+1:`ULFC_LEN_LSB]};
        fmt.parity_on    = lfc_r[`ULFC_PAR_BIT];
        fmt.even         = lfc_r[`ULFC_EVEN_BIT];
        if (!lfc_r[`ULFC_STOP_BIT])                   fmt.stop_halves = 2'h2;
        else if (lfc_r[1:0] == 2'b00)                 fmt.stop_halves = 2'h3;
        else                                          fmt.stop_halves = 2'h0; // Zero means four.
    end

    // ======================================================================
    // Transmit path: FIFO then serialiser.
    // ======================================================================
    logic [7:0] txf_data;   // Head of transmit FIFO.
    logic       txf_valid;  // Head valid.
    logic       txf_pop;    // Serialiser takes a word.
    ulfc_fifo #(.W(8), .AW(`ULFC_FIFO_AW)) u_txf (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .in_data(tx_data), .in_valid(tx_valid), .in_ready(tx_ready),
        .out_data(txf_data), .out_valid(txf_valid), .out_ready(txf_pop), .level());

    ulfc_pkg::ulfc_tx_t tx_st_r;   // Transmit state.
    logic [15:0] tx_cnt_r;         // Cycles within current bit.
    logic [3:0]  tx_idx_r;         // Data bit index or stop half count.
    logic [7:0]  tx_sh_r;          // Word being sent.
    logic        tx_line_r;        // Raw serial level.
    assign txf_pop = (tx_st_r == ulfc_pkg::TX_IDLE) && txf_valid;
    wire tx_bit_end = tx_cnt_r == `ULFC_BIT_CYCLES - 16'h0001;
    wire tx_half_end = tx_cnt_r == (`ULFC_BIT_CYCLES >> 1) - 16'h0001;

    // Serialiser: start, data, optional parity, stop halves.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_st_r <= ulfc_pkg::TX_IDLE;
            tx_cnt_r <= 16'h0000;
            tx_idx_r <= 4'h0;
            tx_sh_r <= 8'h00;
            tx_line_r <= 1'b1;
        end
        else
        begin
            tx_cnt_r <= tx_bit_end ? 16'h0000 : tx_cnt_r + 16'h0001;
            unique case (tx_st_r)
                ulfc_pkg::TX_IDLE:
                begin
                    tx_line_r <= 1'b1;
                    if (txf_valid)
                    begin
                        tx_sh_r <= txf_data;
                        tx_st_r <= ulfc_pkg::TX_START;
                        tx_cnt_r <= 16'h0000;
                        tx_line_r <= 1'b0;
                    end
                end
                ulfc_pkg::TX_START:
                    if (tx_bit_end)
                    begin
                        tx_cnt_r <= 16'h0000;
                        tx_idx_r <= 4'h1;
                        tx_line_r <= tx_sh_r[0];
                        tx_st_r <= ulfc_pkg::TX_DATA;
                    end
                ulfc_pkg::TX_DATA:
                    if (tx_bit_end)
                    begin
                        tx_cnt_r <= 16'h0000;
                        tx_idx_r <= tx_idx_r + 4'h1;
                        if (tx_idx_r < fmt.data_bits)
                            tx_line_r <= tx_sh_r[tx_idx_r[2:0]];
                        else if (fmt.parity_on)
                        begin
                            tx_line_r <= par_of(tx_sh_r, fmt.data_bits, fmt.even);
                            tx_st_r <= ulfc_pkg::TX_PAR;
                        end
                        else
                        begin
                            tx_line_r <= 1'b1;
                            tx_idx_r <= 4'h0;
                            tx_st_r <= ulfc_pkg::TX_STOP;
                        end
                    end
                ulfc_pkg::TX_PAR:
                    if (tx_bit_end)
                    begin
                        tx_cnt_r <= 16'h0000;
                        tx_idx_r <= 4'h0;
                        tx_line_r <= 1'b1;
                        tx_st_r <= ulfc_pkg::TX_STOP;
                    end
                ulfc_pkg::TX_STOP:
                    if (tx_half_end)
                    begin
                        tx_cnt_r <= 16'h0000;
                        tx_idx_r <= tx_idx_r + 4'h1;
                        if (tx_idx_r[1:0] + 2'h1 == fmt.stop_halves)
                            tx_st_r <= ulfc_pkg::TX_IDLE;
                    end
                default: tx_st_r <= ulfc_pkg::TX_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Pin drive: break, loopback and infrared encoding.
    // ======================================================================
    logic tx_eff;   // Transmit level after break.
    logic ir_pulse; // Infrared pulse window within bit.
    assign tx_eff = tx_line_r & ~break_force;
    assign ir_pulse = tx_cnt_r < `ULFC_IR_CYCLES;

    // Outputs registered; loopback parks the pins.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sout <= 1'b1;
            sir_out_n <= 1'b0;
        end
        else
        begin
            // Normal output forced low by break outside loopback and infrared mode.
            sout <= loopback_on | infrared_mode_on | tx_eff;
            if (loopback_on || !infrared_mode_on)
                sir_out_n <= 1'b0;
            else
                sir_out_n <= ~tx_eff & ir_pulse;
        end
    end

    // ======================================================================
    // Receive path.
    // ======================================================================
    logic rx_in; // Selected receive level, break looped when in loopback.
    assign rx_in = loopback_on ? tx_eff : (infrared_mode_on ? ~sir_in : sin);

    ulfc_pkg::ulfc_rx_t rx_st_r; // Receive state.
    logic [15:0] rx_cnt_r;       // Cycles within bit.
    logic [3:0]  rx_idx_r;       // Data bit index.
    logic [7:0]  rx_sh_r;        // Assembled word.
    logic        rx_perr_r;      // Parity error of current word.
    logic        rx_push;        // Word complete.
    logic [`ULFC_FIFO_AW:0] rx_level; // Receive FIFO fill.
    logic        rx_room;        // Receive FIFO ready.
    wire rx_mid = rx_cnt_r == (`ULFC_BIT_CYCLES >> 1) - 16'h0001;
    wire rx_end = rx_cnt_r == `ULFC_BIT_CYCLES - 16'h0001;

    // Deserialiser sampling mid-bit.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_st_r <= ulfc_pkg::RX_IDLE;
            rx_cnt_r <= 16'h0000;
            rx_idx_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_perr_r <= 1'b0;
            rx_push <= 1'b0;
            rx_frame_err <= 1'b0;
            rx_parity_err <= 1'b0;
        end
        else
        begin
            rx_push <= 1'b0;
            rx_cnt_r <= rx_end ? 16'h0000 : rx_cnt_r + 16'h0001;
            unique case (rx_st_r)
                ulfc_pkg::RX_IDLE:
                begin
                    rx_cnt_r <= 16'h0000;
                    if (!rx_in) rx_st_r <= ulfc_pkg::RX_START;
                end
                ulfc_pkg::RX_START:
                    if (rx_mid)
                    begin
                        rx_idx_r <= 4'h0;
                        rx_sh_r <= 8'h00;
                        rx_st_r <= rx_in ? ulfc_pkg::RX_IDLE : ulfc_pkg::RX_DATA;
                    end
                ulfc_pkg::RX_DATA:
                    if (rx_mid)
                    begin
                        rx_sh_r[rx_idx_r[2:0]] <= rx_in;
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (rx_idx_r + 4'h1 == fmt.data_bits)
                            rx_st_r <= fmt.parity_on ? ulfc_pkg::RX_PAR : ulfc_pkg::RX_STOP;
                    end
                ulfc_pkg::RX_PAR:
                    if (rx_mid)
                    begin
                        rx_perr_r <= rx_in != par_of(rx_sh_r, fmt.data_bits, fmt.even);
                        rx_st_r <= ulfc_pkg::RX_STOP;
                    end
                ulfc_pkg::RX_STOP:
                    if (rx_mid)
                    begin
                        // Only the first stop bit is checked.
                        rx_frame_err <= !rx_in;
                        rx_parity_err <= rx_perr_r & fmt.parity_on;
                        rx_perr_r <= 1'b0;
                        rx_push <= 1'b1;
                        rx_st_r <= ulfc_pkg::RX_IDLE;
                    end
                default: rx_st_r <= ulfc_pkg::RX_IDLE;
            endcase
        end
    end

    logic [7:0] rxf_data;  // Receive FIFO head.
    logic       rxf_valid; // Receive FIFO head valid.
    // Words arriving to a full FIFO are dropped.
    ulfc_fifo #(.W(8), .AW(`ULFC_FIFO_AW)) u_rxf (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .in_data(rx_sh_r), .in_valid(rx_push), .in_ready(rx_room),
        .out_data(rxf_data), .out_valid(rxf_valid), .out_ready(rx_ready && !rx_valid),
        .level(rx_level));

    // Output stage register for received words.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end
        else if (rx_valid)
            rx_valid <= 1'b0;
        else if (rxf_valid && rx_ready)
        begin
            rx_valid <= 1'b1;
            rx_data <= rxf_data;
        end
    end

    // RTS: held high in loopback; gated by threshold under auto flow.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b) rts_n <= 1'b1;
        else if (loopback_on) rts_n <= 1'b1;
        else rts_n <= ~rts_req | (auto_flow_on && (rx_level > rx_trigger));
    end

    a_rts_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (auto_flow_on && !loopback_on && rx_level > rx_trigger) |=> rts_n)
        else $error("rts not raised above threshold");
    a_break_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (break_force && !loopback_on && !infrared_mode_on) |=> !sout)
        else $error("break did not hold sout low");
    a_loop_ir_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
        loopback_on |=> !sir_out_n)
        else $error("infrared output not low in loopback");
    a_loop_sout_hi: assert property (@(posedge ref_clk) disable iff (!rst_b)
        loopback_on |=> sout)
        else $error("sout not parked in loopback");
    a_flow_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!fifo_on && !loopback_on && rts_req) |=> !rts_n)
        else $error("auto flow active without fifos");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ((lfc_r & ~`ULFC_LFC_MASK) == 16'h0000) && ((mlc_r & ~`ULFC_MLC_MASK) == 16'h0000))
        else $error("reserved bit set");
    a_ir_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (break_force && infrared_mode_on && !loopback_on && tx_cnt_r == 16'h0000) |=> sir_out_n)
        else $error("infrared break not pulsing");
    a_no_parity: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !fmt.parity_on |-> tx_st_r != ulfc_pkg::TX_PAR)
        else $error("parity sent while disabled");
    c_break: cover property (@(posedge ref_clk) break_force && !sout);
    c_rx_word: cover property (@(posedge ref_clk) rx_valid);
    c_rts_high: cover property (@(posedge ref_clk) auto_flow_on && rts_n);
endmodule : ulfc_top
`default_nettype wire
